// ---- design/flash_ctrl_pkg.sv ----
// shared constants and types of the flash protection and error controller
// Operation
// - twenty byte registers decoded at byte offsets 0 through 0x4C, one per word
// - open, high and low disable bits pick protected program-flash ranges
// - high range ends at top of program flash, 2 to 16 KB
// - low range starts at 0x7F_8000, 1 to 8 KB
// - program-flash protection loaded from flash at reset, writable afterwards
// - erase failure sets status bit 7; write 1 clears; blocks copy
// - program failure sets status bit 6; write 1 clears; blocks copy
// - protected buffer RAM write sets status bit 4; write 1 clears
// - sector state change failure sets bit 3; write 1 clears; blocks copy
// - sector format failure sets bit 2; write 1 clears; blocks copy
// - uncorrectable or busy read sets bit 1; write 1 clears
// - corrected or busy read sets bit 0 unless ignore_single_fault set
// - failed guard byte load at reset leaves buffer partition fully protected
// - user partition writes always allowed and never flag a violation
// - ram_guard_open zero blocks all buffer partition writes; one allows unguarded areas
// - ram_guard_range_disable enables region when zero; size writable only when set
// - guarded region ends at 0x13_FFFF and is 64 times (code+1) bytes
// - six 16-bit command words selected by index, byte access both ways
// - block verify access error on index, active load sequence, bad address
// - section verify checks phrases erased, must not cross 256 KB
// - clearing command_complete_flag launches; device sets it when done
package flash_ctrl_pkg;
   localparam logic [5:0] NUM_REGS = 6'h14;
   localparam logic [4:0] REG_CLKDIV = 5'h00;
   localparam logic [4:0] REG_SECURITY = 5'h01;
   localparam logic [4:0] REG_CMD_INDEX = 5'h02;
   localparam logic [4:0] REG_ECC_INDEX = 5'h03;
   localparam logic [4:0] REG_FLASH_CFG = 5'h04;
   localparam logic [4:0] REG_ERR_CFG = 5'h05;
   localparam logic [4:0] REG_ERR_STAT = 5'h06;
   localparam logic [4:0] REG_CMD_STAT = 5'h07;
   localparam logic [4:0] REG_PF_PROT = 5'h08;
   localparam logic [4:0] REG_RAM_GUARD = 5'h09;
   localparam logic [4:0] REG_CMD_DATA_HI = 5'h0a;
   localparam logic [4:0] REG_CMD_DATA_LO = 5'h0b;
   // flag positions
   localparam int ERASE_ERR_BIT = 7;
   localparam int PROG_ERR_BIT = 6;
   localparam int GUARD_VIOL_BIT = 4;
   localparam int SECT_STATE_BIT = 3;
   localparam int SECT_FMT_BIT = 2;
   localparam int DOUBLE_BIT = 1;
   localparam int SINGLE_BIT = 0;
   localparam logic [7:0] ERR_MASK = 8'hdf;
   localparam logic [7:0] COPY_BLOCK_MASK = 8'hcc;
   localparam int IGNORE_SF_BIT = 4;
   localparam int CC_BIT = 7;
   localparam int ACC_ERR_BIT = 5;
   localparam int PF_VIOL_BIT = 4;
   localparam int MG_ANY_BIT = 1;
   localparam int MG_UNC_BIT = 0;
   localparam int PF_OPEN_BIT = 7;
   localparam int PF_HDIS_BIT = 5;
   localparam int PF_LDIS_BIT = 2;
   localparam int RG_OPEN_BIT = 7;
   localparam int RG_DIS_BIT = 3;
   localparam logic [7:0] RG_FAIL_VALUE = 8'h7f;
   localparam logic [7:0] SECURITY_VALUE = 8'h00;
   // address map of the arrays
   localparam logic [23:0] PF_TOP = 24'h80_0000;
   localparam logic [23:0] HI_MIN_SIZE = 24'h00_0800;
   localparam logic [23:0] LO_BASE = 24'h7f_8000;
   localparam logic [23:0] LO_MIN_SIZE = 24'h00_0400;
   localparam logic [23:0] RG_TOP = 24'h14_0000;
   localparam logic [23:0] RG_STEP = 24'h00_0040;
   localparam logic [6:0] PF_BLOCK_MIN = 7'h78;
   localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
   localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
   localparam logic [2:0] IDX_BLOCK = 3'h0;
   localparam logic [2:0] IDX_SECTION = 3'h2;
   localparam logic [2:0] NUM_WORDS = 3'h6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      S_LOAD = 3'b001,
      S_IDLE = 3'b010,
      S_VERIFY = 3'b100
   } phase_t;

   typedef struct packed {
      logic erase_fail;
      logic program_fail;
      logic sector_state_fail;
      logic sector_format_fail;
      logic read_double;
      logic read_single;
      logic read_busy;
   } flash_evt_t;

   typedef struct packed {
      logic valid;
      logic user;
      logic [22:0] addr;
   } ram_wr_t;

   typedef struct packed {
      logic valid;
      logic block;
      logic [22:0] addr;
      logic [15:0] count;
   } vreq_t;

   typedef struct packed {
      logic done;
      logic any_err;
      logic uncorr_err;
   } vres_t;

   typedef struct packed {
      phase_t phase;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] clkdiv;
      logic [2:0] cmd_idx;
      logic [2:0] ecc_idx;
      logic [7:0] fcfg;
      logic [7:0] errcfg;
      logic [7:0] errstat;
      logic cc;
      logic acc_err;
      logic pf_viol;
      logic mg_any;
      logic mg_unc;
      logic [7:0] pprot;
      logic [7:0] buffer_ram_protection;
      logic [5:0][15:0] words;
      logic ram_ok;
      logic ram_blocked;
      logic copy_en;
      logic pf_prot;
      vreq_t vreq;
      logic irq;
   } state_t;
endpackage

// ---- design/flash_protect_error_ctrl.sv ----
// register file, protection checks and verify command control of the flash controller
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module flash_protect_error_ctrl import flash_ctrl_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic nvm_load_done,
   input wire logic [7:0] nvm_pf_prot,
   input wire logic [7:0] nvm_ram_guard,
   input wire logic nvm_ram_guard_fail,
   input wire flash_evt_t flash_evt,
   input wire ram_wr_t ram_wr,
   output logic ram_wr_ok,
   output logic ram_wr_blocked,
   output logic eeprom_copy_en,
   input wire logic pf_chk_valid,
   input wire logic [22:0] pf_chk_addr,
   output logic pf_protected,
   input wire logic load_field_active,
   output vreq_t verify_req,
   input wire vres_t verify_res,
   output logic err_irq
);
   state_t s_r;
   state_t s_nxt;
   logic wr_fire;
   logic wr_en;
   logic [4:0] wr_idx;
   logic [7:0] wb;
   logic rd_fire;
   logic [4:0] rd_idx;
   logic [7:0] rd_byte;
   logic [7:0] set_v;
   logic [7:0] clr_v;
   logic [23:0] hi_start;
   logic [23:0] lo_end;
   logic hi_hit;
   logic lo_hit;
   logic pf_sel;
   logic [23:0] rg_start;
   logic rg_guarded;
   logic rg_viol;
   logic launch;
   logic [7:0] cmd_code;
   logic [22:0] sec_start;
   logic [23:0] sec_end;
   logic bad_block;
   logic launch_err;
   logic [15:0] cur_word;

   // ------------------------------------------------------------
   // address decode and read mux
   // ------------------------------------------------------------
   assign wr_fire = s_r.awready & awvalid & wvalid;
   assign wr_idx = awaddr[6:2];
   assign wr_en = wr_fire & (awaddr[7:2] < NUM_REGS) & wstrb[0];
   assign wb = wdata[7:0];
   assign rd_fire = s_r.arready & arvalid;
   assign rd_idx = araddr[6:2];
   assign cur_word = (s_r.cmd_idx < NUM_WORDS) ? s_r.words[s_r.cmd_idx] : 16'h0000;

   always_comb begin
      case (rd_idx)
         REG_CLKDIV: rd_byte = s_r.clkdiv;
         REG_SECURITY: rd_byte = SECURITY_VALUE;
         REG_CMD_INDEX: rd_byte = {5'h00, s_r.cmd_idx};
         REG_ECC_INDEX: rd_byte = {5'h00, s_r.ecc_idx};
         REG_FLASH_CFG: rd_byte = s_r.fcfg;
         REG_ERR_CFG: rd_byte = s_r.errcfg;
         REG_ERR_STAT: rd_byte = s_r.errstat;
         REG_CMD_STAT: rd_byte = {s_r.cc, 1'b0, s_r.acc_err, s_r.pf_viol, 2'h0, s_r.mg_any,
                                  s_r.mg_unc};
         REG_PF_PROT: rd_byte = s_r.pprot;
         REG_RAM_GUARD: rd_byte = s_r.buffer_ram_protection;
         REG_CMD_DATA_HI: rd_byte = cur_word[15:8];
         REG_CMD_DATA_LO: rd_byte = cur_word[7:0];
         default: rd_byte = 8'h00;
      endcase
   end

   // ------------------------------------------------------------
   // program-flash and buffer RAM range checks
   // ------------------------------------------------------------
   assign hi_start = PF_TOP - (HI_MIN_SIZE << s_r.pprot[4:3]);
   assign lo_end = LO_BASE + (LO_MIN_SIZE << s_r.pprot[1:0]);
   assign hi_hit = ~s_r.pprot[PF_HDIS_BIT] & ({1'b0, pf_chk_addr} >= hi_start);
   assign lo_hit = ~s_r.pprot[PF_LDIS_BIT] & ({1'b0, pf_chk_addr} >= LO_BASE)
                   & ({1'b0, pf_chk_addr} < lo_end);
   // open mode protects the selected ranges, closed mode protects all but them
   assign pf_sel = s_r.pprot[PF_OPEN_BIT] ? (hi_hit | lo_hit) : ~(hi_hit | lo_hit);

   assign rg_start = RG_TOP - ({15'h0000, s_r.buffer_ram_protection[2:0], 6'h00} + RG_STEP);
   assign rg_guarded = ~s_r.buffer_ram_protection[RG_OPEN_BIT]
                       | (~s_r.buffer_ram_protection[RG_DIS_BIT] & ({1'b0, ram_wr.addr} >= rg_start));
   // the user partition is never guarded, so it never raises the flag
   assign rg_viol = ram_wr.valid & ~ram_wr.user & rg_guarded;

   // ------------------------------------------------------------
   // error flags
   // ------------------------------------------------------------
   always_comb begin
      set_v = 8'h00;
      set_v[ERASE_ERR_BIT] = flash_evt.erase_fail;
      set_v[PROG_ERR_BIT] = flash_evt.program_fail;
      set_v[GUARD_VIOL_BIT] = rg_viol;
      set_v[SECT_STATE_BIT] = flash_evt.sector_state_fail;
      set_v[SECT_FMT_BIT] = flash_evt.sector_format_fail;
      set_v[DOUBLE_BIT] = flash_evt.read_double | flash_evt.read_busy;
      set_v[SINGLE_BIT] = ~s_r.fcfg[IGNORE_SF_BIT]
                          & (flash_evt.read_single | flash_evt.read_busy);
      clr_v = (wr_en && wr_idx == REG_ERR_STAT) ? wb : 8'h00;
   end

   // ------------------------------------------------------------
   // command launch checks
   // ------------------------------------------------------------
   assign cmd_code = s_r.words[0][15:8];
   assign sec_start = {s_r.words[0][6:0], s_r.words[1]};
   assign sec_end = {1'b0, sec_start} + {5'h00, s_r.words[2], 3'h0} - 24'h00_0001;
   assign bad_block = s_r.words[0][6:0] < PF_BLOCK_MIN;
   assign launch = wr_en && wr_idx == REG_CMD_STAT && wb[CC_BIT] && s_r.cc
                   && s_r.phase == S_IDLE;

   always_comb begin
      case (cmd_code)
         CMD_VERIFY_BLOCK: launch_err = (s_r.cmd_idx != IDX_BLOCK) | load_field_active
                                        | bad_block;
         CMD_VERIFY_SECTION: launch_err = (s_r.cmd_idx != IDX_SECTION) | load_field_active
                                          | bad_block | (sec_start[2:0] != 3'h0)
                                          | (sec_end[23:18] != {1'b0, sec_start[22:18]});
         default: launch_err = 1'b1;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      // write channel: both address and data are taken in the same cycle
      s_nxt.awready = awvalid & wvalid & ~s_r.awready & ~s_r.bvalid;
      s_nxt.wready = awvalid & wvalid & ~s_r.awready & ~s_r.bvalid;
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_fire) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = (awaddr[7:2] < NUM_REGS) ? RESP_OKAY : RESP_SLVERR;
      end
      s_nxt.arready = arvalid & ~s_r.arready & ~s_r.rvalid;
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (rd_fire) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = (araddr[7:2] < NUM_REGS) ? RESP_OKAY : RESP_SLVERR;
         s_nxt.rdata = rd_byte;
      end
      // writes while a command runs are the host's fault; they are still applied
      if (wr_en) begin
         case (wr_idx)
            REG_CLKDIV: s_nxt.clkdiv = wb;
            REG_CMD_INDEX: s_nxt.cmd_idx = wb[2:0];
            REG_ECC_INDEX: s_nxt.ecc_idx = wb[2:0];
            REG_FLASH_CFG: s_nxt.fcfg = wb;
            REG_ERR_CFG: s_nxt.errcfg = wb & ERR_MASK;
            REG_CMD_STAT: begin
               if (wb[ACC_ERR_BIT]) begin
                  s_nxt.acc_err = 1'b0;
               end
               if (wb[PF_VIOL_BIT]) begin
                  s_nxt.pf_viol = 1'b0;
               end
            end
            REG_PF_PROT: s_nxt.pprot = wb;
            REG_RAM_GUARD: begin
               s_nxt.buffer_ram_protection[7:3] = wb[7:3];
               if (s_r.buffer_ram_protection[RG_DIS_BIT]) begin
                  s_nxt.buffer_ram_protection[2:0] = wb[2:0];
               end
            end
            REG_CMD_DATA_HI: begin
               if (s_r.cmd_idx < NUM_WORDS) begin
                  s_nxt.words[s_r.cmd_idx][15:8] = wb;
               end
            end
            REG_CMD_DATA_LO: begin
               if (s_r.cmd_idx < NUM_WORDS) begin
                  s_nxt.words[s_r.cmd_idx][7:0] = wb;
               end
            end
            default: begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      s_nxt.errstat = ((s_r.errstat & ~clr_v) | set_v) & ERR_MASK;
      s_nxt.vreq.valid = 1'b0;
      case (s_r.phase)
         S_LOAD: begin
            s_nxt.cc = 1'b0;
            if (nvm_load_done) begin
               s_nxt.pprot = nvm_pf_prot;
               s_nxt.buffer_ram_protection = nvm_ram_guard_fail ? RG_FAIL_VALUE : nvm_ram_guard;
               s_nxt.cc = 1'b1;
               s_nxt.phase = S_IDLE;
            end
         end
         S_IDLE: begin
            if (launch) begin
               s_nxt.mg_any = 1'b0;
               s_nxt.mg_unc = 1'b0;
               if (launch_err) begin
                  s_nxt.acc_err = 1'b1;
               end else begin
                  s_nxt.cc = 1'b0;
                  s_nxt.phase = S_VERIFY;
                  s_nxt.vreq.valid = 1'b1;
                  s_nxt.vreq.block = (cmd_code == CMD_VERIFY_BLOCK);
                  s_nxt.vreq.addr = (cmd_code == CMD_VERIFY_BLOCK) ?
                                    {s_r.words[0][6:0], 16'h0000} : sec_start;
                  s_nxt.vreq.count = s_r.words[2];
               end
            end
         end
         S_VERIFY: begin
            if (verify_res.done) begin
               s_nxt.mg_any = verify_res.any_err;
               s_nxt.mg_unc = verify_res.uncorr_err;
               s_nxt.cc = 1'b1;
               s_nxt.phase = S_IDLE;
            end
         end
         default: s_nxt.phase = S_IDLE;
      endcase
      s_nxt.ram_ok = ram_wr.valid & ~rg_viol;
      s_nxt.ram_blocked = rg_viol;
      s_nxt.copy_en = ~|(s_nxt.errstat & COPY_BLOCK_MASK);
      if (pf_chk_valid) begin
         s_nxt.pf_prot = pf_sel;
      end
      s_nxt.irq = |(s_r.errstat & s_r.errcfg);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.phase <= S_LOAD;
         s_r.buffer_ram_protection <= RG_FAIL_VALUE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid = s_r.rvalid;
   assign rresp = s_r.rresp;
   assign rdata = {24'h00_0000, s_r.rdata};
   assign ram_wr_ok = s_r.ram_ok;
   assign ram_wr_blocked = s_r.ram_blocked;
   assign eeprom_copy_en = s_r.copy_en;
   assign pf_protected = s_r.pf_prot;
   assign verify_req = s_r.vreq;
   assign err_irq = s_r.irq;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_launch_ok;
      launch && !launch_err;
   endsequence

   sequence seq_verify_run;
      s_r.phase == S_VERIFY && !s_r.cc && verify_res.done;
   endsequence

   chk_double_set_wins: assert property (flash_evt.read_double && clr_v[DOUBLE_BIT]
      |=> s_r.errstat[DOUBLE_BIT]) else $error("double fault flag lost to clear");
   chk_single_ignored: assert property (s_r.fcfg[IGNORE_SF_BIT] && !s_r.errstat[SINGLE_BIT]
      |=> !s_r.errstat[SINGLE_BIT]) else $error("single fault set while ignored");
   chk_guard_violation: assert property (ram_wr.valid && !ram_wr.user && !s_r.buffer_ram_protection[RG_OPEN_BIT]
      |=> ram_wr_blocked && !ram_wr_ok && s_r.errstat[GUARD_VIOL_BIT])
      else $error("closed buffer partition write not blocked");
   chk_user_allowed: assert property (ram_wr.valid && ram_wr.user
      |=> ram_wr_ok && !ram_wr_blocked) else $error("user partition write blocked");
   chk_size_locked: assert property (wr_en && wr_idx == REG_RAM_GUARD
      && !s_r.buffer_ram_protection[RG_DIS_BIT] && s_r.phase != S_LOAD
      |=> s_r.buffer_ram_protection[2:0] == $past(s_r.buffer_ram_protection[2:0])) else $error("guard size written");
   chk_load_fail: assert property (s_r.phase == S_LOAD && nvm_load_done && nvm_ram_guard_fail
      |=> s_r.buffer_ram_protection == 8'h7f && s_r.cc) else $error("failed load left guard open");
   chk_copy_gate: assert property (|(s_r.errstat & COPY_BLOCK_MASK) |-> !eeprom_copy_en)
      else $error("copy enabled with emulated eeprom error");
   chk_launch_error: assert property (launch && launch_err
      |=> s_r.acc_err && s_r.cc && s_r.phase == S_IDLE && !verify_req.valid)
      else $error("bad launch not refused");
   chk_launch_start: assert property (seq_launch_ok
      |=> verify_req.valid && !s_r.cc ##1 !verify_req.valid)
      else $error("verify request not one pulse");
   chk_verify_done: assert property (seq_verify_run |=> s_r.cc && s_r.phase == S_IDLE)
      else $error("command complete not set after verify");
   chk_pf_full: assert property (pf_chk_valid && s_r.pprot[7] == 1'b0 && s_r.pprot[5]
      && s_r.pprot[2] |=> pf_protected) else $error("closed mode did not protect");
   chk_irq_gate: assert property (|(s_r.errstat & s_r.errcfg) |=> err_irq)
      else $error("enabled error flag raised no interrupt");

   // ------------------------------------------------------------
   // bus, load and flag checks
   // ------------------------------------------------------------
   // a dropped response would hang the host for good
   sequence seq_write_taken;
      wr_fire;
   endsequence

   sequence seq_read_taken;
      rd_fire;
   endsequence

   chk_write_resp: assert property (
      seq_write_taken |=> bvalid && !awready)
      else $error("write taken without response");
   chk_read_resp: assert property (
      seq_read_taken |=> rvalid && !arready)
      else $error("read taken without response");
   chk_unmapped_err: assert property (
      wr_fire && awaddr[7:2] >= NUM_REGS |=> bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_pf_load: assert property (
      s_r.phase == S_LOAD && nvm_load_done |=> s_r.pprot == $past(nvm_pf_prot))
      else $error("protection byte not loaded");
   chk_erase_flag: assert property (
      flash_evt.erase_fail |=> s_r.errstat[ERASE_ERR_BIT])
      else $error("erase failure not flagged");
   chk_viol_clear: assert property (
      clr_v[GUARD_VIOL_BIT] && !rg_viol |=> !s_r.errstat[GUARD_VIOL_BIT])
      else $error("violation flag not cleared");
   chk_section_cross: assert property (
      launch && cmd_code == CMD_VERIFY_SECTION
      && sec_end[23:18] != {1'b0, sec_start[22:18]} |=> s_r.acc_err)
      else $error("boundary crossing not refused");
endmodule // flash_protect_error_ctrl

// ---- bench/flash_array_model.sv ----
// flash array side model: reset-time load and verify answers
`timescale 1ns/1ps
module flash_array_model import flash_ctrl_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic guard_fail,
   input wire logic [7:0] pf_img,
   input wire logic [3:0] latency,
   input wire logic [1:0] verify_err,
   input wire vreq_t verify_req,
   output vres_t verify_res,
   output logic nvm_load_done,
   output logic [7:0] nvm_pf_prot,
   output logic [7:0] nvm_ram_guard,
   output logic nvm_ram_guard_fail
);
   logic [3:0] tick_r, wait_r;
   logic busy_r, fin;
   // bytes toggle until done so an early sample cannot pass by luck
   assign nvm_load_done = tick_r[3];
   assign nvm_pf_prot = nvm_load_done ? pf_img : {tick_r, ~tick_r};
   assign nvm_ram_guard = nvm_load_done ? 8'h5a : {~tick_r, tick_r};
   assign nvm_ram_guard_fail = nvm_load_done & guard_fail;
   assign fin = busy_r & (wait_r == 4'h0);
   // margins mean nothing outside the done pulse
   assign verify_res = {fin, fin ? verify_err : wait_r[1:0]};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_r <= 4'h0;
         busy_r <= 1'b0;
         wait_r <= 4'h0;
      end else begin
         if (!tick_r[3]) begin
            tick_r <= tick_r + 4'h1;
         end
         if (verify_req.valid) begin
            busy_r <= 1'b1;
            wait_r <= latency;
         end else if (fin) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            wait_r <= wait_r - 4'h1;
         end
      end
   end
endmodule // flash_array_model

// ---- bench/tb.sv ----
// self-checking bench of the flash protection and error controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb import flash_ctrl_pkg::*;;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, pf_chk_valid = 1'b0, load_field_active = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ram_wr_ok, ram_wr_blocked, blk;
   logic eeprom_copy_en, pf_protected, err_irq, nvm_load_done, nvm_ram_guard_fail;
   logic [7:0] awaddr = '0, araddr = '0, pf_img = '0, nvm_pf_prot, nvm_ram_guard, rd, g, v;
   logic [31:0] wdata = '0, rdata;
   logic [1:0] bresp, rresp, rsp, verify_err = '0;
   logic [3:0] latency = '0;
   logic [22:0] pf_chk_addr = '0;
   logic [15:0] w;
   logic [23:0] c;
   flash_evt_t flash_evt = '0;
   ram_wr_t ram_wr = '0, rw;
   vreq_t verify_req;
   vres_t verify_res;
   integer seed = 32'hf2b8_46c0, n_errors = 0, comparisons = 0, n_req = 0, exp_req = 0;
   logic [7:0] fexp [7] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01, 8'h03};
   // code, block byte, index, then load-active and refusal bits
   logic [23:0] vcase [7] = '{24'h02_7c00, 24'h02_7c11, 24'h02_7c03, 24'h02_1001,
      24'h03_7c20, 24'h03_7c01, 24'h05_7c01};

   always #2.5 aclk = ~aclk;
   always @(posedge aclk) if (verify_req.valid === 1'b1) n_req++;

   flash_protect_error_ctrl i_flash_protect_error_ctrl (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb(4'h1), .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .nvm_load_done, .nvm_pf_prot,
      .nvm_ram_guard, .nvm_ram_guard_fail, .flash_evt, .ram_wr, .ram_wr_ok, .ram_wr_blocked,
      .eeprom_copy_en, .pf_chk_valid, .pf_chk_addr, .pf_protected, .load_field_active,
      .verify_req, .verify_res, .err_irq);
   flash_array_model i_flash_array_model (.aclk, .aresetn, .guard_fail(1'b1), .pf_img,
      .latency, .verify_err, .verify_req, .verify_res, .nvm_load_done, .nvm_pf_prot,
      .nvm_ram_guard, .nvm_ram_guard_fail);

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 1'b0;
      rsp = bresp;
      @(posedge aclk);
   endtask
   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rready <= 1'b0;
      rd = rdata[7:0];
      rsp = rresp;
      @(posedge aclk);
   endtask
   task automatic evt(input logic [6:0] e);
      flash_evt <= e;
      @(posedge aclk) flash_evt <= '0;
      @(posedge aclk);
   endtask
   task automatic setw(input logic [2:0] i, input logic [15:0] d);
      wr(8'h08, {5'h00, i});
      wr(8'h28, d[15:8]);
      wr(8'h2c, d[7:0]);
   endtask
   function automatic logic pf_exp(input logic [7:0] p, input logic [22:0] a);
      logic hit;
      hit = (!p[5] && {1'b0, a} >= 24'h80_0000 - (24'h00_0800 << p[4:3]))
         || (!p[2] && a >= 23'h7f_8000 && a < 23'h7f_8000 + (23'h00_0400 << p[1:0]));
      return p[7] ? hit : !hit;
   endfunction
   task automatic finish_test;
      if (n_errors == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #50_000;
      n_errors++;
      finish_test;
   end
   initial begin
      pf_img = 8'($random(seed));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      do rdr(8'h1c); while (rd[7] !== 1'b1);
      rdr(8'h24);
      `CHK("guard", 8'h7f, rd)
      rdr(8'h20);
      `CHK("pprot", pf_img, rd)
      rdr(8'h50);
      `CHK("resp", 2'h2, rsp)
      rdr(8'h4c);
      `CHK("resp", 2'h0, rsp)
      wr(8'h14, 8'hff);
      for (int i = 0; i < 7; i++) begin
         evt(7'h40 >> i);
         rdr(8'h18);
         `CHK("flags", fexp[i], rd)
         `CHK("copy", ~|(fexp[i] & 8'hcc), eeprom_copy_en)
         `CHK("irq", 1'b1, err_irq)
         wr(8'h18, 8'h00);
         rdr(8'h18);
         `CHK("w0", fexp[i], rd)
         wr(8'h18, fexp[i]);
         rdr(8'h18);
         `CHK("w1c", 8'h00, rd)
         `CHK("irq", 1'b0, err_irq)
      end
      wr(8'h10, 8'h10);
      evt(7'h02);
      rdr(8'h18);
      `CHK("ignore", 8'h00, rd)
      for (int i = 0; i < 24; i++) begin
         v = 8'($random(seed));
         wr(8'h20, v);
         pf_chk_addr <= {7'h7f, 16'($random(seed))};
         pf_chk_valid <= 1'b1;
         @(posedge aclk) pf_chk_valid <= 1'b0;
         @(posedge aclk) `CHK("pf", pf_exp(v, pf_chk_addr), pf_protected)
      end
      g = 8'h7f;
      for (int i = 0; i < 16; i++) begin
         v = i == 0 ? 8'h8d : i == 1 ? 8'h80 : 8'($random(seed));
         wr(8'h24, v);
         g = {v[7:3], g[3] ? v[2:0] : g[2:0]};
         rdr(8'h24);
         `CHK("guard", g, rd)
         rw = {1'b1, 1'($random(seed)), 23'h13_fc00 | 23'($random(seed) & 1023)};
         blk = !rw.user && (!g[7] || (!g[3] && rw.addr >= 23'h14_0000 - 64 * (g[2:0] + 1)));
         ram_wr <= rw;
         @(posedge aclk) ram_wr <= '0;
         @(posedge aclk) `CHK("blocked", blk, ram_wr_blocked)
         `CHK("ok", !blk, ram_wr_ok)
         rdr(8'h18);
         `CHK("viol", {3'h0, blk, 4'h0}, rd)
         wr(8'h18, 8'h10);
      end
      for (int i = 0; i < 7; i++) begin
         w = 16'($random(seed));
         setw(3'(i), w);
         rdr(8'h28);
         `CHK("word_hi", i < 6 ? w[15:8] : 8'h00, rd)
         rdr(8'h2c);
         `CHK("word_lo", i < 6 ? w[7:0] : 8'h00, rd)
      end
      for (int i = 0; i < 7; i++) begin
         c = vcase[i];
         setw(3'h0, c[23:8]);
         setw(3'h1, 16'h1000);
         setw(3'h2, 16'h0010);
         wr(8'h08, {5'h00, c[6:4]});
         load_field_active <= c[1];
         latency <= 4'($random(seed));
         verify_err <= 2'($random(seed));
         wr(8'h1c, 8'h80);
         exp_req += !c[0];
         do rdr(8'h1c); while (rd[7] !== 1'b1);
         `CHK("launch", exp_req, n_req)
         if (c[0]) begin
            `CHK("acc_err", 1'b1, rd[5])
            wr(8'h1c, 8'h20);
         end else begin
            `CHK("margin", verify_err, rd[1:0])
            `CHK("kind", !c[16], verify_req.block)
         end
         load_field_active <= 1'b0;
      end
      finish_test;
   end
endmodule // tb
